// File: core/rfid_block_cmd.sv
`timescale 1ns/1ps
`include "rfid_cmd_cfg.svh"
module rfid_block_cmd #(
    parameter int NUM_BLOCKS  = 128,
    parameter int T1_CYCLES   = `NOMINAL_RESPONSE_DELAY_CYC,
    parameter int STEP_CYCLES = `WT_STEP_CYC,
    parameter int WT_STEPS    = `WT_STEPS_DEF
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    // Link from reader
    input  wire logic        link_clk_i,
    input  wire logic        link_data_i,
    input  wire logic        link_frame_i,
    // Tag identity and state
    input  wire logic [63:0] tag_uid_i,
    input  wire logic        tag_selected_i,
    // Area protection and EEPROM status
    input  wire logic        area_read_protected_i,
    input  wire logic        area_write_protected_i,
    input  wire logic        prog_fail_i,
    // Response toward modulator
    input  wire logic        tx_ready_i,
    output logic             tx_valid_o,
    output logic [7:0]       tx_data_o,
    output logic             tx_last_o,
    // Status
    output logic             busy_o,
    output logic [1:0]       lock_state_o
);
    localparam int AW       = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;
    localparam int WT_TOTAL = T1_CYCLES + WT_STEPS * STEP_CYCLES;

    generate
        if (NUM_BLOCKS < `LOCKABLE_BLOCKS || NUM_BLOCKS > 65536 ||
            WT_TOTAL < 1 || WT_STEPS < 0) begin : g_bad_params
            $error("rfid_block_cmd: unsupported parameter values");
        end
    endgenerate

    rfid_cmd_pkg::fsm_type  state;
    rfid_cmd_pkg::byte_type rx_buf [0:`RX_DEPTH-1];
    logic [31:0]            mem [0:NUM_BLOCKS-1];
    logic [4:0]             rx_cnt;
    logic [1:0]             lock_bits;
    logic [31:0]            prog_cnt;
    logic [AW-1:0]          tgt_idx;
    logic [31:0]            tgt_data;
    logic                   tgt_lock;
    logic                   tgt_opt;
    logic [47:0]            rsp_shift;
    logic [2:0]             rsp_cnt;

    wire                    rx_byte;
    wire [7:0]              rx_data;
    wire                    rx_start;
    wire                    rx_end;

    rfid_link_rx u_rx (
        .ref_clk_i     (ref_clk_i),
        .sys_rst_i     (sys_rst_i),
        .link_clk_i    (link_clk_i),
        .link_data_i   (link_data_i),
        .link_frame_i  (link_frame_i),
        .byte_valid_o  (rx_byte),
        .byte_data_o   (rx_data),
        .frame_start_o (rx_start),
        .frame_end_o   (rx_end)
    );

    function automatic logic block_locked(input logic [15:0] blk, input logic [1:0] bits);
        block_locked = (blk < 16'(`LOCKABLE_BLOCKS)) && bits[blk[0]];
    endfunction : block_locked

    // Request field decode
    wire [7:0]  flags     = rx_buf[0];
    wire [7:0]  cmd       = rx_buf[1];
    wire        is_ext    = cmd == `CMD_XREAD || cmd == `CMD_XWRITE;
    wire        is_rd     = cmd == `CMD_READ || cmd == `CMD_XREAD;
    wire        is_wr     = cmd == `CMD_WRITE || cmd == `CMD_XWRITE;
    wire        is_lock   = cmd == `CMD_LOCK;
    wire        known     = rx_cnt >= 5'd2 && (is_rd || is_wr || is_lock);
    wire        adr       = flags[`FLAG_ADDRESS];
    wire        opt       = flags[`FLAG_OPTION];
    wire [4:0]  pos       = adr ? `POS_ADDRESSED : `POS_PLAIN;
    wire [4:0]  blk_bytes = is_ext ? 5'd2 : 5'd1;
    wire [4:0]  dpos      = 5'(pos + blk_bytes);
    wire [4:0]  exp_len   = 5'(dpos + (is_wr ? 5'd4 : 5'd0) + `CRC_BYTES);
    wire [7:0]  blk_hi    = is_ext ? rx_buf[5'(pos + 5'd1)] : 8'h00;
    wire [15:0] blk       = {blk_hi, rx_buf[pos]};
    wire [31:0] wdata;
    wire [63:0] rx_uid;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_wdata
            assign wdata[8*gi +: 8] = rx_buf[5'(dpos + 5'(gi))];
        end
        for (gi = 0; gi < 8; gi++) begin : g_uid
            assign rx_uid[8*gi +: 8] = rx_buf[`POS_PLAIN + gi];
        end
    endgenerate

    wire uid_match = adr && rx_uid == tag_uid_i;
    wire addr_ok   = adr ? uid_match : (!flags[`FLAG_SELECT] || tag_selected_i);
    wire flag_err  = flags[`FLAG_INVENTORY] ||
                     (flags[`FLAG_SELECT] && flags[`FLAG_ADDRESS]);
    wire len_bad   = rx_cnt != exp_len;
    wire blk_lck   = block_locked(blk, lock_bits);
    wire blk_none  = {1'b0, blk} >= 17'(NUM_BLOCKS) ||
                     (is_lock && blk >= 16'(`LOCKABLE_BLOCKS));
    wire silent    = !known || (flag_err ? !uid_match : !addr_ok);
    wire [AW-1:0] idx = blk[AW-1:0];
    wire [7:0] sec_byte = {7'h00, blk_lck};

    wire [7:0] err_code =
        flag_err                                      ? `ERR_OPTION    :
        len_bad                                       ? `ERR_UNSPEC    :
        blk_none                                      ? `ERR_NO_BLOCK  :
        is_rd && area_read_protected_i                ? `ERR_RD_PROT   :
        is_wr && (blk_lck || area_write_protected_i)  ? `ERR_WR_LOCKED :
        is_lock && blk_lck                            ? `ERR_RELOCK    :
                                                        8'h00;

    wire prog_done = state == rfid_cmd_pkg::S_PROG && prog_cnt == 32'(WT_TOTAL - 1);
    wire prog_bad  = prog_done && prog_fail_i;
    wire [7:0] prog_err = tgt_lock ? `ERR_LOCK_FAIL : `ERR_PROG_FAIL;

    assign tx_valid_o   = state == rfid_cmd_pkg::S_SEND;
    assign tx_data_o    = rsp_shift[7:0];
    assign tx_last_o    = tx_valid_o && rsp_cnt == 3'h1;
    assign busy_o       = state == rfid_cmd_pkg::S_PROG;
    assign lock_state_o = lock_bits;

    // Request capture
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_cnt <= 5'h00;
        end else if (state == rfid_cmd_pkg::S_IDLE && rx_start) begin
            rx_cnt <= 5'h00;
        end else if (state == rfid_cmd_pkg::S_IDLE && rx_byte && rx_cnt != 5'h1F) begin
            rx_cnt <= 5'(rx_cnt + 5'h01);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (state == rfid_cmd_pkg::S_IDLE && rx_byte && rx_cnt < 5'(`RX_DEPTH)) begin
            rx_buf[rx_cnt] <= rx_data;
        end
    end

    // Block memory and lock bits
    always_ff @(posedge ref_clk_i) begin
        if (prog_done && !prog_fail_i && !tgt_lock) begin
            mem[tgt_idx] <= tgt_data;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lock_bits <= 2'h0;
        end else if (prog_done && !prog_fail_i && tgt_lock) begin
            lock_bits[tgt_idx[0]] <= 1'b1;
        end
    end

    // Programming timer
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_cnt <= 32'h0;
        end else if (state == rfid_cmd_pkg::S_PROG) begin
            prog_cnt <= prog_cnt + 32'h1;
        end else begin
            prog_cnt <= 32'h0;
        end
    end

    // Command sequencer
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state     <= rfid_cmd_pkg::S_IDLE;
            rsp_shift <= 48'h0;
            rsp_cnt   <= 3'h0;
            tgt_idx   <= '0;
            tgt_data  <= 32'h0;
            tgt_lock  <= 1'b0;
            tgt_opt   <= 1'b0;
        end else begin
            unique case (state)
                rfid_cmd_pkg::S_IDLE: begin
                    if (rx_end) begin
                        state <= rfid_cmd_pkg::S_DECODE;
                    end
                end
                rfid_cmd_pkg::S_DECODE: begin
                    if (silent) begin
                        state <= rfid_cmd_pkg::S_IDLE;
                    end else if (err_code != 8'h00) begin
                        rsp_shift <= {32'h0, err_code, `RSP_ERROR};
                        rsp_cnt   <= 3'h2;
                        state     <= rfid_cmd_pkg::S_SEND;
                    end else if (is_rd) begin
                        if (opt) begin
                            rsp_shift <= {mem[idx], sec_byte, `RSP_OK};
                            rsp_cnt   <= 3'h6;
                        end else begin
                            rsp_shift <= {8'h00, mem[idx], `RSP_OK};
                            rsp_cnt   <= 3'h5;
                        end
                        state <= rfid_cmd_pkg::S_SEND;
                    end else begin
                        tgt_idx  <= idx;
                        tgt_data <= wdata;
                        tgt_lock <= is_lock;
                        tgt_opt  <= opt;
                        state    <= rfid_cmd_pkg::S_PROG;
                    end
                end
                rfid_cmd_pkg::S_PROG: begin
                    if (prog_done) begin
                        rsp_shift <= prog_bad ? {32'h0, prog_err, `RSP_ERROR}
                                              : {40'h0, `RSP_OK};
                        rsp_cnt   <= prog_bad ? 3'h2 : 3'h1;
                        state     <= tgt_opt ? rfid_cmd_pkg::S_WAIT_EOF
                                             : rfid_cmd_pkg::S_SEND;
                    end
                end
                rfid_cmd_pkg::S_WAIT_EOF: begin
                    if (rx_end) begin
                        state <= rfid_cmd_pkg::S_SEND;
                    end
                end
                rfid_cmd_pkg::S_SEND: begin
                    if (tx_ready_i) begin
                        rsp_shift <= {8'h00, rsp_shift[47:8]};
                        rsp_cnt   <= 3'(rsp_cnt - 3'h1);
                        if (rsp_cnt == 3'h1) begin
                            state <= rfid_cmd_pkg::S_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic [31:0] busy_len;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_len <= 32'h0;
        end else begin
            busy_len <= busy_o ? busy_len + 32'h1 : 32'h0;
        end
    end

    wire decode_ok = state == rfid_cmd_pkg::S_DECODE && !silent && err_code == 8'h00;

    sequence seq_prog_end;
        busy_o ##1 !busy_o;
    endsequence

    a_prog_length: assert property (seq_prog_end |-> $past(busy_len) == 32'(WT_TOTAL - 1))
        else $error("programming cycle length wrong");
    a_quiet_prog: assert property (busy_o |-> !tx_valid_o)
        else $error("response sent during programming");
    a_eof_defer: assert property (
        (state == rfid_cmd_pkg::S_WAIT_EOF && !rx_end) |=> !tx_valid_o)
        else $error("deferred response sent before EOF");
    a_err_frame: assert property (
        (state == rfid_cmd_pkg::S_DECODE && !silent && err_code != 8'h00)
        |=> tx_valid_o && tx_data_o == `RSP_ERROR && rsp_cnt == 3'h2
            && rsp_shift[15:8] == $past(err_code))
        else $error("error frame malformed");
    a_sec_status: assert property (
        (decode_ok && is_rd && opt)
        |=> rsp_shift[15:9] == 7'h00 && rsp_shift[8] == $past(blk_lck) && rsp_cnt == 3'h6)
        else $error("security status byte wrong");
    a_read_plain: assert property ((decode_ok && is_rd && !opt) |=> rsp_cnt == 3'h5)
        else $error("plain read response length wrong");
    a_flag_silent: assert property (
        (state == rfid_cmd_pkg::S_DECODE && known && flag_err && !uid_match)
        |=> state == rfid_cmd_pkg::S_IDLE ##1 !tx_valid_o)
        else $error("flag misuse answered without UID");
    a_locked_write: assert property (
        (state == rfid_cmd_pkg::S_DECODE && !silent && is_wr && !flag_err && !len_bad
         && !blk_none && blk_lck) |=> rsp_shift[15:8] == `ERR_WR_LOCKED)
        else $error("write to locked block not refused");
    a_lock_source: assert property (
        lock_bits != $past(lock_bits) |-> $past(prog_done) && $past(tgt_lock))
        else $error("lock bit changed outside a lock cycle");
    a_ok_write_frame: assert property (
        (prog_done && !prog_fail_i) |=> rsp_cnt == 3'h1 && rsp_shift[7:0] == `RSP_OK)
        else $error("write success frame wrong");

endmodule : rfid_block_cmd

// File: core/rfid_cmd_cfg.svh
`ifndef RFID_CMD_CFG_SVH
`define RFID_CMD_CFG_SVH

// Command codes
`define CMD_READ        8'h20
`define CMD_WRITE       8'h21
`define CMD_LOCK        8'h22
`define CMD_XREAD       8'h30
`define CMD_XWRITE      8'h31

// Error codes
`define ERR_OPTION      8'h03
`define ERR_UNSPEC      8'h0F
`define ERR_NO_BLOCK    8'h10
`define ERR_RELOCK      8'h11
`define ERR_WR_LOCKED   8'h12
`define ERR_PROG_FAIL   8'h13
`define ERR_LOCK_FAIL   8'h14
`define ERR_RD_PROT     8'h15

// Request flag positions and response flags
`define FLAG_INVENTORY  2
`define FLAG_SELECT     4
`define FLAG_ADDRESS    5
`define FLAG_OPTION     6
`define RSP_OK          8'h00
`define RSP_ERROR       8'h01

// Frame layout
`define POS_PLAIN       5'd2
`define POS_ADDRESSED   5'd10
`define CRC_BYTES       5'd2
`define RX_DEPTH        20
`define LOCKABLE_BLOCKS 2

// Timing
`define CLK_PERIOD_NS   8
`define NOMINAL_RESPONSE_DELAY_NS        320000
`define WT_STEP_NS      302000
`define WT_STEPS_DEF    16
`define NOMINAL_RESPONSE_DELAY_CYC       ((`NOMINAL_RESPONSE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WT_STEP_CYC     ((`WT_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: core/rfid_cmd_pkg.sv
package rfid_cmd_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_DECODE,
        S_PROG,
        S_WAIT_EOF,
        S_SEND
    } fsm_type;

    typedef logic [7:0] byte_type;

endpackage : rfid_cmd_pkg

// File: core/rfid_link_rx.sv
`timescale 1ns/1ps
module rfid_link_rx (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    // Link pins
    input  wire logic       link_clk_i,
    input  wire logic       link_data_i,
    input  wire logic       link_frame_i,
    // Received stream
    output logic            byte_valid_o,
    output logic [7:0]      byte_data_o,
    output logic            frame_start_o,
    output logic            frame_end_o
);
    logic [1:0] clk_sync;
    logic [1:0] data_sync;
    logic [1:0] frame_sync;
    logic       clk_last;
    logic       frame_last;
    logic [7:0] shifter;
    logic [2:0] bit_cnt;
    wire        clk_rise;
    wire        take_bit;

    // Two-stage synchronisers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_sync   <= 2'h0;
            data_sync  <= 2'h0;
            frame_sync <= 2'h0;
            clk_last   <= 1'b0;
            frame_last <= 1'b0;
        end else begin
            clk_sync   <= {clk_sync[0], link_clk_i};
            data_sync  <= {data_sync[0], link_data_i};
            frame_sync <= {frame_sync[0], link_frame_i};
            clk_last   <= clk_sync[1];
            frame_last <= frame_sync[1];
        end
    end

    assign clk_rise      = clk_sync[1] & ~clk_last;
    assign take_bit      = clk_rise & frame_sync[1];
    assign frame_start_o = frame_sync[1] & ~frame_last;
    assign frame_end_o   = ~frame_sync[1] & frame_last;

    // Bits arrive least significant first
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shifter      <= 8'h00;
            bit_cnt      <= 3'h0;
            byte_valid_o <= 1'b0;
            byte_data_o  <= 8'h00;
        end else begin
            byte_valid_o <= take_bit && bit_cnt == 3'h7;
            if (frame_start_o) begin
                bit_cnt <= 3'h0;
            end else if (take_bit) begin
                shifter <= {data_sync[1], shifter[7:1]};
                bit_cnt <= 3'(bit_cnt + 3'h1);
                if (bit_cnt == 3'h7) begin
                    byte_data_o <= {data_sync[1], shifter[7:1]};
                end
            end
        end
    end

endmodule : rfid_link_rx

// File: dv/rfid_reader_model.sv
`timescale 1ns/1ps
module rfid_reader_model (
    // Clock and tag status
    input  wire logic ref_clk_i,
    input  wire logic busy_i,
    // Link pins
    output logic      link_clk_o,
    output logic      link_data_o,
    output logic      link_frame_o,
    // Wait bound used up
    output logic      wait_expired_o
);
    initial begin
        wait_expired_o = 1'b0;
        link_clk_o   = 1'b0;
        link_data_o  = 1'b0;
        link_frame_o = 1'b0;
    end

    // Half a link bit is 80 ns
    task automatic half_bit();
        repeat (10) @(negedge ref_clk_i);
    endtask : half_bit

    // One frame, each byte LSB first; an empty queue is a bare EOF
    task automatic send_frame(input logic [7:0] bytes[$]);
        int w;
        w = 0;
        // No modulation for up to 2000 cycles while the tag programs
        while (busy_i === 1'b1 && w < 2000) begin
            @(negedge ref_clk_i);
            w++;
        end
        if (w >= 2000) begin
            wait_expired_o = 1'b1;
        end
        @(negedge ref_clk_i);
        link_frame_o = 1'b1;
        half_bit();
        foreach (bytes[i]) begin
            for (int b = 0; b < 8; b++) begin
                link_data_o = bytes[i][b];
                half_bit();
                link_clk_o = 1'b1;
                half_bit();
                link_clk_o = 1'b0;
            end
        end
        half_bit();
        // Frame fall is the EOF; released data line no longer shows the last bit
        link_frame_o = 1'b0;
        link_data_o  = ~link_data_o;
    endtask : send_frame
endmodule : rfid_reader_model

// File: dv/test_rfid_block_cmd.sv
`timescale 1ns/1ps
`include "rfid_cmd_cfg.svh"
`define CHECK(a, e, m) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: %s", $time, m); end end
module test_rfid_block_cmd;
    typedef struct {
        logic [7:0]  flags;
        logic [7:0]  cmd;
        logic [47:0] pay;
        int          plen;
        int          uid;
        logic [3:0]  ctl;
        logic [47:0] exp;
        int          elen;
    } row_type;
    row_type     rows [25];
    row_type     opt_row;
    logic [7:0]  none_q[$];
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        link_clk, link_data, link_frame;
    logic [63:0] tag_uid;
    logic        tag_sel, rd_prot, wr_prot, prog_fail, tx_ready;
    logic        wait_expired;
    logic        tx_valid, tx_last, busy;
    logic [7:0]  tx_data;
    logic [1:0]  lock_state;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          n;
    logic [47:0] got;

    always #4 ref_clk_i = ~ref_clk_i;

    rfid_block_cmd #(.NUM_BLOCKS(128), .T1_CYCLES(20), .STEP_CYCLES(10), .WT_STEPS(2)) dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk),
        .link_data_i(link_data), .link_frame_i(link_frame), .tag_uid_i(tag_uid),
        .tag_selected_i(tag_sel), .area_read_protected_i(rd_prot),
        .area_write_protected_i(wr_prot), .prog_fail_i(prog_fail), .tx_ready_i(tx_ready),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last), .busy_o(busy),
        .lock_state_o(lock_state));

    rfid_reader_model reader (
        .ref_clk_i(ref_clk_i), .busy_i(busy), .link_clk_o(link_clk),
        .link_data_o(link_data), .link_frame_o(link_frame),
        .wait_expired_o(wait_expired));

    task automatic finish_test();
        $display("errors %0d, checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // Takes response bytes; the modulator stalls for the first 8 cycles
    task automatic get_rsp(input int lim, output int cnt, output logic [47:0] bytes);
        cnt = 0;
        bytes = '0;
        for (int i = 0; i < lim; i++) begin
            @(negedge ref_clk_i);
            tx_ready = (i >= 8);
            if (tx_valid === 1'b1 && tx_ready === 1'b1 && cnt < 6) begin
                bytes[8*cnt +: 8] = tx_data;
                cnt++;
                if (tx_last === 1'b1) break;
            end
        end
    endtask : get_rsp

    task automatic send_row(input row_type r);
        logic [7:0] q[$];
        @(negedge ref_clk_i);
        {tag_sel, rd_prot, wr_prot, prog_fail} = r.ctl;
        q = {r.flags, r.cmd};
        for (int i = 0; i < 8 && r.uid > 0; i++) begin
            q.push_back(r.uid == 1 ? tag_uid[8*i +: 8] : ~tag_uid[8*i +: 8]);
        end
        for (int i = 0; i < r.plen; i++) begin
            q.push_back(r.pay[8*i +: 8]);
        end
        q.push_back(8'hC0);
        q.push_back(8'hC1);
        reader.send_frame(q);
    endtask : send_row

    task automatic run_row(input row_type r);
        send_row(r);
        get_rsp(300, n, got);
        `CHECK(n, r.elen, "response length")
        `CHECK(got, r.exp, "response bytes")
        if (n < r.elen) finish_test();
    endtask : run_row

    initial begin
        repeat (100000) @(posedge ref_clk_i);
        error_cnt++;
        finish_test();
    end

    initial begin
        {tag_sel, rd_prot, wr_prot, prog_fail, tx_ready} = 5'h00;
        tag_uid = 64'h0123456789ABCDEF;
        rows[0]  = '{8'h00, `CMD_WRITE, 48'h4433221103, 5, 0, 4'h0, 48'h00, 1};
        rows[1]  = '{8'h00, `CMD_READ, 48'h03, 1, 0, 4'h0, 48'h4433221100, 5};
        rows[2]  = '{8'h40, `CMD_READ, 48'h03, 1, 0, 4'h0, 48'h443322110000, 6};
        rows[3]  = '{8'h20, `CMD_READ, 48'h03, 1, 1, 4'h0, 48'h4433221100, 5};
        rows[4]  = '{8'h20, `CMD_READ, 48'h03, 1, 2, 4'h0, 48'h00, 0};
        rows[5]  = '{8'h00, `CMD_XWRITE, 48'hDDCCBBAA0105, 6, 0, 4'h0, 48'h1001, 2};
        rows[6]  = '{8'h00, `CMD_XWRITE, 48'hDDCCBBAA0005, 6, 0, 4'h0, 48'h00, 1};
        rows[7]  = '{8'h00, `CMD_XREAD, 48'h0005, 2, 0, 4'h0, 48'hDDCCBBAA00, 5};
        rows[8]  = '{8'h00, `CMD_XREAD, 48'h0100, 2, 0, 4'h0, 48'h1001, 2};
        rows[9]  = '{8'h00, `CMD_READ, 48'h03, 1, 0, 4'h4, 48'h1501, 2};
        rows[10] = '{8'h00, `CMD_XREAD, 48'h0003, 2, 0, 4'h4, 48'h1501, 2};
        rows[11] = '{8'h00, `CMD_WRITE, 48'h4433221103, 5, 0, 4'h2, 48'h1201, 2};
        rows[12] = '{8'h00, `CMD_WRITE, 48'h4433221103, 5, 0, 4'h1, 48'h1301, 2};
        rows[13] = '{8'h00, `CMD_READ, 48'h00, 0, 0, 4'h0, 48'h0F01, 2};
        rows[14] = '{8'h00, `CMD_WRITE, 48'h44332211C8, 5, 0, 4'h0, 48'h1001, 2};
        rows[15] = '{8'h04, `CMD_READ, 48'h03, 1, 0, 4'h0, 48'h00, 0};
        rows[16] = '{8'h24, `CMD_READ, 48'h03, 1, 1, 4'h0, 48'h0301, 2};
        rows[17] = '{8'h10, `CMD_READ, 48'h03, 1, 0, 4'h8, 48'h4433221100, 5};
        rows[18] = '{8'h00, `CMD_WRITE, 48'h5566778801, 5, 0, 4'h0, 48'h00, 1};
        rows[19] = '{8'h00, `CMD_LOCK, 48'h01, 1, 0, 4'h0, 48'h00, 1};
        rows[20] = '{8'h00, `CMD_LOCK, 48'h01, 1, 0, 4'h0, 48'h1101, 2};
        rows[21] = '{8'h00, `CMD_LOCK, 48'h02, 1, 0, 4'h0, 48'h1001, 2};
        rows[22] = '{8'h00, `CMD_WRITE, 48'h0000000001, 5, 0, 4'h0, 48'h1201, 2};
        rows[23] = '{8'h40, `CMD_READ, 48'h01, 1, 0, 4'h0, 48'h556677880100, 6};
        rows[24] = '{8'h00, `CMD_LOCK, 48'h00, 1, 0, 4'h1, 48'h1401, 2};
        opt_row  = '{8'h40, `CMD_WRITE, 48'h0403020104, 5, 0, 4'h0, 48'h00, 1};
        repeat (10) @(negedge ref_clk_i);
        `CHECK({tx_valid, tx_last, busy, lock_state}, 5'h00, "reset outputs")
        repeat (10) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        foreach (rows[i]) run_row(rows[i]);
        `CHECK(lock_state, 2'h2, "lock state")
        // Option write: programming runs, answer waits for the bare EOF
        send_row(opt_row);
        repeat (10) @(negedge ref_clk_i);
        `CHECK(busy, 1'b1, "busy in programming")
        get_rsp(200, n, got);
        `CHECK(n, 0, "answer before EOF")
        reader.send_frame(none_q);
        get_rsp(100, n, got);
        `CHECK(n, 1, "answer after EOF length")
        `CHECK(got, 48'h00, "answer after EOF")
        run_row('{8'h00, `CMD_READ, 48'h04, 1, 0, 4'h0, 48'h0403020100, 5});
        // Select flag while not selected: no answer
        run_row('{8'h10, `CMD_READ, 48'h03, 1, 0, 4'h0, 48'h00, 0});
        // Identity changes: addressed read follows the new UID
        tag_uid = 64'hFEDCBA9876543210;
        run_row(rows[3]);
        // Reset in mid programming
        send_row(rows[0]);
        repeat (10) @(negedge ref_clk_i);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        `CHECK({tx_valid, busy}, 2'h0, "mid reset outputs")
        sys_rst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        `CHECK({tx_valid, busy, lock_state}, 4'h0, "outputs after release")
        run_row(rows[1]);
        `CHECK(wait_expired, 1'b0, "reader wait expired")
        finish_test();
    end
endmodule : test_rfid_block_cmd
